// [design/ddma_core.sv]
`timescale 1ns/1ps
module ddma_core #(
    parameter int DEPTH = 64
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic formatter_byte_strobe_i,
    input wire logic [7:0] formatter_data_i,
    output logic [7:0] formatter_data_o,
    input wire logic memory_data_strobe_n_i,
    input wire logic request_accept_n_i,
    input wire logic [15:0] memory_data_i,
    output logic memory_request_o,
    output logic [15:0] data_to_memory_lines_o,
    output logic memory_driver_enable_o,
    input wire logic status_request_i,
    output logic [15:0] a_reg_data_o,
    output logic transfer_complete_o,
    output logic lost_data_o
);
    // ----------------------------------------
    // state and storage
    // ----------------------------------------
    ddma_pkg::ddma_st_t s;
    ddma_pkg::ddma_st_t n;
    ddma_pkg::ddma_pin_t pins;
    logic [15:0] fifo_mem [0:DEPTH-1];
    logic [7:0] file_mem [0:15];
    logic push;
    logic pop_now;
    logic [15:0] push_dat;
    logic fm_we;
    logic [15:0] amux;

    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
        lane16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : lane16

    function automatic logic [15:0] dec16(input logic [15:0] v);
        dec16 = (v != 16'h0000) ? v - 16'h0001 : v;
    endfunction : dec16

    assign pins = '{fbs: formatter_byte_strobe_i, mds_n: memory_data_strobe_n_i,
                    ra_n: request_accept_n_i, streq: status_request_i,
                    fdat: formatter_data_i, mdat: memory_data_i};

    // ----------------------------------------
    // derived conditions
    // ----------------------------------------
    logic rd;
    logic wr;
    logic go;
    logic fbs_ev;
    logic mds_ev;
    logic f_empty;
    logic f_full;
    logic wc_zero;
    logic bc_zero;
    logic lost_cond;
    logic [1:0] sel;
    assign rd = s.ctrl[ddma_pkg::C_READ];
    assign wr = s.ctrl[ddma_pkg::C_WRITE];
    assign go = s.ctrl[ddma_pkg::C_GO];
    assign fbs_ev = s.p2.fbs & ~s.fbs_d;
    assign mds_ev = ~s.p2.mds_n & s.mds_d;
    assign f_empty = (s.cnt == 7'h00);
    assign f_full = (s.cnt == 7'(DEPTH));
    assign wc_zero = (s.wc == 16'h0000);
    assign bc_zero = (s.bc == 16'h0000);
    assign lost_cond = (rd & f_full) | (wr & ~s.full); // R12 R13

    // ----------------------------------------
    // a-register multiplexer
    // ----------------------------------------
    logic [7:0] stat8;
    assign stat8 = {2'b00, f_full, f_empty, s.req, s.full, s.lost, transfer_complete_o};
    assign sel = s.p2.streq ? 2'b01 : {s.ctrl[ddma_pkg::C_SEL1], s.ctrl[ddma_pkg::C_SEL0]}; // R18
    always_comb begin
        case (sel) // R17
            2'b00: amux = {s.r1, file_mem[s.bc[3:0]]};
            2'b01: amux = {stat8, stat8};
            2'b10: amux = s.ctrl[ddma_pkg::C_R1HI] ? {s.r1, 8'h00} : {8'h00, s.r1}; // R19
            default: amux = 16'h0000;
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = s;
        push = 1'b0;
        pop_now = 1'b0;
        push_dat = 16'h0000;
        fm_we = 1'b0;
        n.p1 = pins;
        n.p2 = s.p1;
        n.fbs_d = s.p2.fbs;
        n.mds_d = s.p2.mds_n;
        n.ack = 1'b0;
        // memory side
        if (mds_ev && s.req) begin
            n.req = 1'b0; // R02
            if (wr) begin
                push = 1'b1; // R21
                push_dat = s.p2.mdat;
                n.wc = dec16(s.wc); // R22
            end else if (rd) begin
                n.full = 1'b0; // R08
            end
        end else if (!s.req && go && s.pop == 2'b00) begin
            if (wr && !wc_zero && !f_full) begin
                n.req = 1'b1; // R23
            end else if (rd && s.full && s.ctrl[ddma_pkg::C_PROT]) begin
                n.req = 1'b1; // R01 R03
            end
        end
        // formatter side
        if (fbs_ev) begin
            n.lost = lost_cond | s.lost; // R14
            if (!go) begin
                fm_we = rd; // R05
                if (rd) begin
                    n.bc = dec16(s.bc);
                end
            end else if (rd && !wc_zero && !f_full) begin
                n.bc = dec16(s.bc); // R04
                n.in_lo = ~s.in_lo; // R20
                if (!s.in_lo) begin
                    n.hold = s.p2.fdat;
                end else begin
                    push = 1'b1;
                    push_dat = {s.hold, s.p2.fdat};
                    n.wc = dec16(s.wc); // R22
                end
            end else if (wr) begin
                n.fdo = s.out_lo ? s.oreg[7:0] : s.oreg[15:8]; // R16
                if (s.full) begin
                    n.bc = dec16(s.bc); // R04
                    n.out_lo = ~s.out_lo;
                    if (s.out_lo) begin
                        n.full = 1'b0; // R08
                        n.oreg = 16'h0000; // R16
                    end
                end
            end
        end
        // fifo pop pulse
        if (s.pop != 2'b00) begin
            n.pop = s.pop - 2'b01;
            if (s.pop == 2'b01) begin
                pop_now = 1'b1;
                n.oreg = fifo_mem[s.rp];
            end
        end else if (!s.full && !f_empty) begin
            n.pop = 2'(ddma_pkg::POP_CYC); // R07
            n.full = 1'b1; // R07
        end
        if (push) begin
            n.wp = s.wp + 6'h01;
        end
        if (pop_now) begin
            n.rp = s.rp + 6'h01;
        end
        n.cnt = s.cnt + {6'h00, push} - {6'h00, pop_now};
        // empty timer
        if (!f_empty) begin
            n.ecnt = 7'h00;
        end else if (s.ecnt != 7'(ddma_pkg::EMPTY_CYC)) begin
            n.ecnt = s.ecnt + 7'h01;
        end
        // bus slave
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            n.ack = 1'b1;
            n.rdat = 32'h0000_0000;
            if (wb_adr_i == ddma_pkg::ADR_CTRL) begin
                n.rdat = {24'h000000, s.ctrl};
                if (wb_we_i && wb_sel_i[0]) begin
                    n.ctrl = wb_dat_i[7:0];
                end
            end else if (wb_adr_i == ddma_pkg::ADR_CMD) begin
                if (wb_we_i && wb_sel_i[0]) begin
                    if (wb_dat_i[ddma_pkg::K_CLEAR_ADAPTER_CMD] && !(fbs_ev && lost_cond)) begin
                        n.lost = 1'b0; // R15
                    end
                    if (wb_dat_i[ddma_pkg::K_FCLR]) begin
                        n.wp = 6'h00;
                        n.rp = 6'h00;
                        n.cnt = 7'h00;
                        n.pop = 2'b00;
                        n.in_lo = 1'b0;
                        n.out_lo = 1'b0;
                        n.full = 1'b0;
                        n.req = 1'b0;
                    end
                end
            end else if (wb_adr_i == ddma_pkg::ADR_WCNT) begin
                n.rdat = {16'h0000, s.wc};
                if (wb_we_i) begin
                    n.wc = lane16(s.wc, wb_dat_i, wb_sel_i);
                end
            end else if (wb_adr_i == ddma_pkg::ADR_BCNT) begin
                n.rdat = {16'h0000, s.bc};
                if (wb_we_i) begin
                    n.bc = lane16(s.bc, wb_dat_i, wb_sel_i);
                end
            end else if (wb_adr_i == ddma_pkg::ADR_R1) begin
                n.rdat = {24'h000000, s.r1};
                if (wb_we_i && wb_sel_i[0]) begin
                    n.r1 = wb_dat_i[7:0];
                end
            end else if (wb_adr_i == ddma_pkg::ADR_STAT) begin
                n.rdat = {24'h000000, stat8}; // R11
            end else if (wb_adr_i == ddma_pkg::ADR_AMUX) begin
                n.rdat = {16'h0000, amux};
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0; // R24
            s.p1.mds_n <= 1'b1;
            s.p2.mds_n <= 1'b1;
            s.mds_d <= 1'b1;
            s.p1.ra_n <= 1'b1;
            s.p2.ra_n <= 1'b1;
            s.ctrl <= ddma_pkg::CTRL_RST;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (push) begin
            fifo_mem[s.wp] <= push_dat;
        end
        if (fm_we) begin
            file_mem[s.bc[3:0]] <= s.p2.fdat;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        if (s.ctrl[ddma_pkg::C_TEST]) begin
            transfer_complete_o = wc_zero; // R10
        end else begin
            transfer_complete_o = wc_zero && (s.ecnt == 7'(ddma_pkg::EMPTY_CYC))
                                  && bc_zero && !s.full; // R09
        end
    end
    assign memory_request_o = s.req;
    assign memory_driver_enable_o = s.req & rd & ~s.p2.ra_n; // R06
    assign data_to_memory_lines_o = s.oreg;
    assign formatter_data_o = s.fdo;
    assign a_reg_data_o = amux;
    assign lost_data_o = s.lost;
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;
endmodule : ddma_core

// [design/ddma_pkg.sv]
// Function
// (R01) disk read: request memory whenever the output register holds a full word
// (R02) memory data strobe clears the memory request in both directions
// (R03) disk read memory writes only while protect permission is set
// (R04) byte count decrements once per byte transferred, read or write
// (R05) file memory store strobe only while transfer go is clear
// (R06) memory drivers enabled while request accept is low during reads
// (R07) empty register and fifo ready fire a 100 ns pop pulse, set full
// (R08) full clears on memory store (read) or second byte sent (write)
// (R09) complete: words zero, fifo empty 5 us, bytes zero, register empty
// (R10) test mode: complete depends only on word count zero
// (R11) transfer complete is offered as a testable condition
// (R12) read: lost data when a byte arrives and fifo is full
// (R13) write: lost data when a byte is requested and register is empty
// (R14) lost data flag captures the combined condition on each byte strobe
// (R15) clear adapter command clears the lost data flag
// (R16) write: output register cleared between output words
// (R17) a-register mux: LL r1/file, HL status, LH zero/r1, HH zeros
// (R18) mux select from control, host status request forces status
// (R19) control bit places r1 in upper or lower half
// (R20) read: alternate upper/lower fifo halves while word count nonzero
// (R21) write: both fifo halves loaded on each memory data word
// (R22) word count decrements once per 16-bit word moved
// (R23) write: request while word count nonzero and fifo accepts input
// (R24) reset clears request, full, lost flags and empties fifo
package ddma_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_WCNT = 8'h08;
    localparam logic [7:0] ADR_BCNT = 8'h0c;
    localparam logic [7:0] ADR_R1 = 8'h10;
    localparam logic [7:0] ADR_STAT = 8'h14;
    localparam logic [7:0] ADR_AMUX = 8'h18;
    // ----------------------------------------
    // control bits
    // ----------------------------------------
    localparam int C_READ = 0;
    localparam int C_WRITE = 1;
    localparam int C_GO = 2;
    localparam int C_TEST = 3;
    localparam int C_PROT = 4;
    localparam int C_R1HI = 5;
    localparam int C_SEL0 = 6;
    localparam int C_SEL1 = 7;
    localparam int K_CLEAR_ADAPTER_CMD = 0;
    localparam int K_FCLR = 1;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 40;
    localparam int POP_NS = 100;
    localparam int EMPTY_US = 5;
    localparam int POP_CYC = (POP_NS + CLK_NS - 1) / CLK_NS;
    localparam int EMPTY_CYC = (EMPTY_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int FIFO_DEPTH = 64;
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic fbs;
        logic mds_n;
        logic ra_n;
        logic streq;
        logic [7:0] fdat;
        logic [15:0] mdat;
    } ddma_pin_t;
    typedef struct packed {
        ddma_pin_t p1;
        ddma_pin_t p2;
        logic fbs_d;
        logic mds_d;
        logic [7:0] ctrl;
        logic [15:0] wc;
        logic [15:0] bc;
        logic [7:0] r1;
        logic [5:0] wp;
        logic [5:0] rp;
        logic [6:0] cnt;
        logic [7:0] hold;
        logic in_lo;
        logic out_lo;
        logic [1:0] pop;
        logic full;
        logic [15:0] oreg;
        logic req;
        logic lost;
        logic [6:0] ecnt;
        logic [7:0] fdo;
        logic ack;
        logic [31:0] rdat;
    } ddma_st_t;
endpackage : ddma_pkg

// [verification/ddma_mem_model.sv]
`timescale 1ns/1ps
module ddma_mem_model (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic req_i,
    input wire logic [15:0] dtm_i,
    input wire logic [3:0] wait_i,
    output logic strobe_n_o,
    output logic accept_n_o,
    output logic [15:0] data_o,
    output logic [15:0] got_o
);
    logic [4:0] t_r;
    logic [15:0] w_r;
    logic [4:0] b;
    assign b = {1'b0, wait_i};
    // accept low across the strobe, word taken mid strobe
    assign accept_n_o = !(t_r > b && t_r < b + 5'h7);
    assign strobe_n_o = !(t_r > b + 5'h2 && t_r < b + 5'h7);
    assign data_o = strobe_n_o ? ~w_r : w_r;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            t_r <= 5'h0;
            w_r <= 16'h1234;
            got_o <= 16'h0;
        end else if (t_r == 5'h0) begin
            t_r <= {4'h0, req_i};
        end else if (t_r < b + 5'h7) begin
            t_r <= t_r + 5'h1;
            if (t_r == b + 5'h5) got_o <= dtm_i;
        end else if (!req_i) begin
            t_r <= 5'h0;
            w_r <= w_r + 16'h1;
        end
    end
endmodule : ddma_mem_model

// [verification/ddma_monitor.sv]
`timescale 1ns/1ps
module ddma_monitor (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic formatter_byte_strobe_i,
    input wire logic memory_data_strobe_n_i,
    input wire logic memory_request_o,
    input wire logic memory_driver_enable_o,
    input wire logic [15:0] data_to_memory_lines_o,
    input wire logic status_request_i,
    input wire logic [15:0] a_reg_data_o,
    input wire logic lost_data_o
);
    // ----
    // cycles since each strobe
    // ----
    logic [3:0] sc_r;
    logic [3:0] mc_r;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sc_r <= 4'hf;
            mc_r <= 4'hf;
        end else begin
            sc_r <= formatter_byte_strobe_i ? 4'h0 : sc_r + {3'h0, sc_r != 4'hf};
            mc_r <= !memory_data_strobe_n_i ? 4'h0 : mc_r + {3'h0, mc_r != 4'hf};
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_stat;
        status_request_i [*5];
    endsequence
    AST_ACK_LAT: assert property (s_req |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_EN_REQ: assert property (memory_driver_enable_o |-> memory_request_o)
        else $error("driver enabled without request");
    AST_REQ_CLR: assert property ($fell(memory_data_strobe_n_i) |-> ##[1:6] !memory_request_o)
        else $error("request not cleared by strobe");
    AST_REQ_SRC: assert property ($fell(memory_request_o) && $past(memory_driver_enable_o)
        |-> mc_r < 4'h8)
        else $error("request dropped without strobe");
    AST_DTM_HOLD: assert property (memory_driver_enable_o && $past(memory_driver_enable_o)
        |-> $stable(data_to_memory_lines_o))
        else $error("memory word moved while driven");
    AST_LOST_SRC: assert property ($rose(lost_data_o) |-> sc_r < 4'h8)
        else $error("lost flag set without byte strobe");
    AST_STAT_SEL: assert property (s_stat |-> a_reg_data_o[15:8] == a_reg_data_o[7:0])
        else $error("status request not forcing status");
endmodule : ddma_monitor
bind ddma_core ddma_monitor ddma_monitor_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .formatter_byte_strobe_i(formatter_byte_strobe_i),
    .memory_data_strobe_n_i(memory_data_strobe_n_i), .memory_request_o(memory_request_o),
    .memory_driver_enable_o(memory_driver_enable_o),
    .data_to_memory_lines_o(data_to_memory_lines_o), .status_request_i(status_request_i),
    .a_reg_data_o(a_reg_data_o), .lost_data_o(lost_data_o));

// [verification/disk_dma_fifo_transfer_control_test.sv]
`timescale 1ns/1ps
module disk_dma_fifo_transfer_control_test;
    typedef struct packed {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] exp;
    } ddma_row_t;
    localparam ddma_row_t ROWS [7] = '{'{8'h08, 32'h0000abcd, 8'h08, 32'h0000abcd},
        '{8'h0c, 32'hffff1234, 8'h0c, 32'h00001234}, '{8'h10, 32'h1a5, 8'h10, 32'ha5},
        '{8'h20, 32'h55, 8'h20, 32'h0}, '{8'h00, 32'h80, 8'h18, 32'h00a5},
        '{8'h00, 32'ha0, 8'h18, 32'ha500}, '{8'h00, 32'hc0, 8'h18, 32'h0}};
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic fbs = 1'b0;
    logic st = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [7:0] fdi = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] mwait = 4'h6;
    logic [31:0] rdat, q;
    logic [7:0] fdo;
    logic ack, mds_n, ra_n, req, den, tc, lost;
    logic [15:0] mdi, dtm, areg, got;
    int err_count = 0;
    int checked = 0;
    always #20 mclk_i = ~mclk_i;
    ddma_core ddma_core_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .formatter_byte_strobe_i(fbs),
        .formatter_data_i(fdi), .formatter_data_o(fdo), .memory_data_strobe_n_i(mds_n),
        .request_accept_n_i(ra_n), .memory_data_i(mdi), .memory_request_o(req),
        .data_to_memory_lines_o(dtm), .memory_driver_enable_o(den),
        .status_request_i(st), .a_reg_data_o(areg), .transfer_complete_o(tc),
        .lost_data_o(lost));
    ddma_mem_model ddma_mem_model_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req),
        .dtm_i(dtm), .wait_i(mwait), .strobe_n_o(mds_n), .accept_n_o(ra_n), .data_o(mdi),
        .got_o(got));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk_i);
    endtask : wb
    task automatic fb(input logic [7:0] d);
        fdi <= d;
        @(posedge mclk_i);
        fbs <= 1'b1;
        repeat (4) @(posedge mclk_i);
        fbs <= 1'b0;
        repeat (5) @(posedge mclk_i);
    endtask : fb
    task automatic wait_got(input logic [15:0] w);
        int n;
        n = 0;
        while (got !== w && n < 200) begin
            @(posedge mclk_i);
            n++;
        end
        chk({16'h0, got}, {16'h0, w});
    endtask : wait_got
    task automatic test_done;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        chk({30'h0, req, lost}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, ROWS[i].wa, ROWS[i].wd);
            wb(1'b0, ROWS[i].ra, 32'h0);
            chk(q, ROWS[i].exp);
            if (ROWS[i].ra == 8'h18) chk({16'h0, areg}, ROWS[i].exp);
        end
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h08, 32'h2);
        wb(1'b1, 8'h0c, 32'h4);
        wb(1'b1, 8'h00, 32'h15);
        fb(8'h11);
        fb(8'h22);
        wait_got(16'h1122);
        mwait <= 4'h0;
        fb(8'h33);
        fb(8'h44);
        wait_got(16'h3344);
        chk({31'h0, tc}, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 8'h0c, 32'h0);
        chk(q, 32'h0);
        repeat (140) @(posedge mclk_i);
        chk({31'h0, tc}, 32'h1);
        wb(1'b0, 8'h14, 32'h0);
        chk({31'h0, q[0]}, 32'h1);
        fb(8'h55);
        chk({31'h0, req}, 32'h0);
        wb(1'b1, 8'h04, 32'h2);
        wb(1'b1, 8'h08, 32'h1);
        wb(1'b1, 8'h00, 32'h05);
        fb(8'h66);
        fb(8'h77);
        repeat (20) @(posedge mclk_i);
        chk({31'h0, req}, 32'h0);
        wb(1'b1, 8'h04, 32'h2);
        wb(1'b1, 8'h08, 32'h1);
        wb(1'b1, 8'h00, 32'h06);
        repeat (40) @(posedge mclk_i);
        fb(8'h00);
        chk({24'h0, fdo}, 32'h12);
        fb(8'h00);
        chk({24'h0, fdo}, 32'h36);
        fb(8'h00);
        chk({24'h0, fdo}, 32'h0);
        chk({31'h0, lost}, 32'h1);
        wb(1'b1, 8'h04, 32'h1);
        chk({31'h0, lost}, 32'h0);
        wb(1'b1, 8'h08, 32'h40);
        wb(1'b1, 8'h00, 32'h08);
        chk({31'h0, tc}, 32'h0);
        wb(1'b1, 8'h08, 32'h0);
        chk({31'h0, tc}, 32'h1);
        st <= 1'b1;
        repeat (8) @(posedge mclk_i);
        st <= 1'b0;
        test_done();
    end
    initial begin
        #(40 * 20000);
        err_count++;
        test_done();
    end
endmodule : disk_dma_fifo_transfer_control_test
